// ==== design/swg_watchdog.sv ====
/*
 * gated standard watchdog core with its APB register slave.
 * assumes all pins synchronous to pclk; presetn acts as power-on reset
 * and supply_ok reports the supply above its operating minimum.
 */
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module swg_watchdog import swg_pkg::*; #(
    parameter int P_PROBE_CYC = PROBE_CYC,
    parameter int P_STARTUP_CYC = STARTUP_CYC,
    parameter int P_RST_CYC = RST_CYC,
    parameter int P_WD_LONG_CYC = WD_LONG_CYC,
    parameter int P_WD_SHORT_CYC = WD_SHORT_CYC,
    parameter int P_CAP_SLOPE_CYC = CAP_SLOPE_CYC,
    parameter int P_CAP_BASE_CYC = CAP_BASE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic [1:0] timeout_config_pin,
    input wire logic timer_arm_select,
    input wire logic gate_in,
    input wire logic kick_in,
    output logic expiry_out_n,
    output logic gate_status_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        swg_state_e st;
        logic [31:0] cnt;
        logic [31:0] gdly;
        logic kick_q;
        logic [1:0] opt;
        logic expiry_n;
        logic gate_status;
        logic [15:0] kicks;
    } swg_core_s;

    swg_core_s q;
    swg_core_s nxt_q;
    swg_apb_req_s req;
    swg_stat_s stat;
    logic [CAP_W-1:0] cap_nf;
    logic [31:0] timeout_cyc;
    logic kick_fall;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};
    assign stat = '{st: q.st, opt: q.opt, expiry_n: q.expiry_n,
                    gate_status: q.gate_status, kicks: q.kicks};

    // ------------------------------------------------------------
    // timeout selection and kick edge
    // ------------------------------------------------------------
    always_comb begin
        case (q.opt)
            OPT_PULLUP: timeout_cyc = 32'(P_WD_SHORT_CYC); // [RL6]
            OPT_CAP: timeout_cyc = 32'(cap_nf) * 32'(P_CAP_SLOPE_CYC)
                + 32'(P_CAP_BASE_CYC); // [RL7]
            default: timeout_cyc = 32'(P_WD_LONG_CYC); // [RL5]
        endcase
    end

    // falling edge only; levels and rises do nothing
    assign kick_fall = q.kick_q && !kick_in; // [RL1]

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_q = q;
        nxt_q.kick_q = kick_in;
        case (q.st)
            S_LOWSUP: begin
                // table level taken for expiry here, status held low
                nxt_q.gate_status = 1'b0; // [RL19]
                nxt_q.expiry_n = 1'b1;
                nxt_q.cnt = 32'h0000_0000;
                if (supply_ok) begin
                    nxt_q.st = S_PROBE;
                end
            end
            S_PROBE: begin
                nxt_q.cnt = q.cnt + 32'h0000_0001;
                // kicks ignored until probing ends
                if (q.cnt == 32'(P_STARTUP_CYC - 1)) begin
                    nxt_q.gate_status = 1'b1; // [RL18]
                end
                if (q.cnt == 32'(P_PROBE_CYC - 1)) begin
                    nxt_q.opt = (timeout_config_pin == OPT_CAP
                        || timeout_config_pin == OPT_PULLUP)
                        ? timeout_config_pin : OPT_OPEN; // [RL8]
                    nxt_q.cnt = 32'h0000_0000;
                    nxt_q.st = timer_arm_select ? S_RUN : S_OFF;
                end
            end
            S_OFF: begin
                nxt_q.expiry_n = 1'b1; // [RL9]
                nxt_q.cnt = 32'h0000_0000;
                if (timer_arm_select) begin
                    nxt_q.st = S_SETTLE;
                end
            end
            S_SETTLE: begin
                // kicks seen here are dropped on purpose
                nxt_q.cnt = q.cnt + 32'h0000_0001; // [RL10]
                if (!timer_arm_select) begin
                    nxt_q.st = S_OFF;
                end else if (q.cnt == 32'(SETTLE_CYC - 1)) begin
                    nxt_q.cnt = 32'h0000_0000;
                    nxt_q.st = S_RUN;
                end
            end
            S_RUN: begin
                if (!timer_arm_select) begin
                    nxt_q.st = S_OFF; // [RL9]
                end else if (kick_fall) begin
                    nxt_q.cnt = 32'h0000_0000; // [RL2] [RL4]
                    nxt_q.kicks = q.kicks + 16'h0001;
                end else if (q.cnt >= timeout_cyc - 32'h0000_0001) begin
                    nxt_q.expiry_n = 1'b0; // [RL3] [RL2]
                    nxt_q.cnt = 32'h0000_0000;
                    nxt_q.st = S_EXPIRE;
                end else begin
                    nxt_q.cnt = q.cnt + 32'h0000_0001;
                end
            end
            S_EXPIRE: begin
                nxt_q.cnt = q.cnt + 32'h0000_0001;
                if (!timer_arm_select) begin
                    nxt_q.expiry_n = 1'b1;
                    nxt_q.st = S_OFF;
                end else if (q.cnt == 32'(P_RST_CYC - 1)) begin
                    nxt_q.expiry_n = 1'b1; // [RL20]
                    nxt_q.cnt = 32'h0000_0000;
                    nxt_q.st = S_RUN;
                end
            end
            S_GATED: begin
                // held low gate keeps the timer off indefinitely
                nxt_q.expiry_n = 1'b1; // [RL13] [RL14] [RL12]
                if (q.gdly == 32'(GATE_DLY_CYC - 1)) begin
                    nxt_q.gate_status = 1'b0; // [RL13]
                end else begin
                    nxt_q.gdly = q.gdly + 32'h0000_0001;
                end
                if (gate_in) begin
                    nxt_q.cnt = 32'h0000_0000;
                    nxt_q.st = S_RELEASE;
                end
            end
            S_RELEASE: begin
                // short gate pulses still give one full reset cycle
                nxt_q.gate_status = 1'b0; // [RL12]
                nxt_q.cnt = q.cnt + 32'h0000_0001;
                if (q.cnt == 32'(P_RST_CYC - 1)) begin
                    nxt_q.gate_status = 1'b1; // [RL16]
                    nxt_q.expiry_n = 1'b1;
                    nxt_q.cnt = 32'h0000_0000;
                    nxt_q.st = timer_arm_select ? S_RUN : S_OFF; // [RL15]
                end
            end
            default: begin
                nxt_q.st = S_LOWSUP;
            end
        endcase
        // gate low outranks select; pin pull-up lives outside [RL17]
        if (q.st != S_LOWSUP && q.st != S_PROBE && q.st != S_GATED
            && !gate_in) begin
            nxt_q.st = S_GATED; // [RL14]
            nxt_q.gdly = 32'h0000_0000;
            nxt_q.expiry_n = 1'b1; // [RL13]
        end
        // supply loss outranks everything and forces a new probe
        if (!supply_ok) begin
            nxt_q.st = S_LOWSUP; // [RL19]
            nxt_q.gate_status = 1'b0;
            nxt_q.expiry_n = 1'b1;
            nxt_q.cnt = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{st: S_LOWSUP, cnt: 32'h0000_0000, gdly: 32'h0000_0000,
                   kick_q: 1'b1, opt: OPT_OPEN, expiry_n: 1'b1,
                   gate_status: 1'b0, kicks: 16'h0000};
        end else begin
            q <= nxt_q;
        end
    end

    assign expiry_out_n = q.expiry_n;
    assign gate_status_out = q.gate_status;

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    swg_regs u_swg_regs (
        .pclk(pclk),
        .presetn(presetn),
        .req(req),
        .stat(stat),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cap_nf(cap_nf)
    );

endmodule : swg_watchdog

// ==== design/swg_pkg.sv ====
/*
 * constants, state codes, register map and carrier structs of the
 * gated standard watchdog.
 * assumes a single 20 MHz clock pclk and an APB register bus.
 */
// How it works
// RL1 - only a falling kick edge services the watchdog
// RL2 - interval between falling kicks decides released or asserted expiry
// RL3 - no kick within the active timeout drives expiry low
// RL4 - supervisor must kick before the shortest timeout elapses
// RL5 - unconnected config, select high: 1600 ms timeout
// RL6 - pulled-up config, select high: 200 ms timeout
// RL7 - capacitor config: timeout is 77.4 ms per nF plus 55 ms
// RL8 - after supply rise, probe config for 381 us and latch option
// RL9 - select low disables timer and ignores kicks
// RL10 - after re-enable, kicks ignored for 150 us settle time
// RL11 - supervisor uses select, not gate, for long disables
// RL12 - short gate low gives one reset cycle, held low disables
// RL13 - gate low: status low after 200 ns, expiry released; gate is not sampled during the power-up probe, status rises at 300 us
// RL14 - while gate low, kicks are disregarded
// RL15 - gate high again resumes normal kick handling
// RL16 - after gate high, status and expiry release after 200 ms
// RL17 - undriven gate input counts as high
// RL18 - at power-up, status low and kicks ignored for 300 us; kicks stay ignored until the 381 us probe ends
// RL19 - below operating supply, status low, kicks ignored
// RL20 - expiry held low for reset delay, then count restarts
package swg_pkg;

    // ------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int NS_PER_MS = 1000000;
    localparam int CYC_PER_US = CLK_KHZ / 1000;
    localparam int PROBE_US = 381;
    localparam int STARTUP_US = 300;
    localparam int SETTLE_US = 150;
    localparam int GATE_DLY_NS = 200;
    localparam int RST_MS = 200;
    localparam int WD_LONG_MS = 1600;
    localparam int WD_SHORT_MS = 200;
    localparam int CAP_SLOPE_TENTH_MS = 774;
    localparam int CAP_BASE_MS = 55;

    localparam int PROBE_CYC = PROBE_US * CYC_PER_US;
    localparam int STARTUP_CYC = STARTUP_US * CYC_PER_US;
    localparam int SETTLE_CYC = SETTLE_US * CYC_PER_US;
    localparam int GATE_DLY_RAW = (GATE_DLY_NS * CLK_KHZ) / NS_PER_MS;
    localparam int GATE_DLY_CYC = (GATE_DLY_RAW < 1) ? 1 : GATE_DLY_RAW;
    localparam int RST_CYC = RST_MS * CLK_KHZ;
    localparam int WD_LONG_CYC = WD_LONG_MS * CLK_KHZ;
    localparam int WD_SHORT_CYC = WD_SHORT_MS * CLK_KHZ;
    localparam int CAP_SLOPE_CYC = (CAP_SLOPE_TENTH_MS * CLK_KHZ) / 10;
    localparam int CAP_BASE_CYC = CAP_BASE_MS * CLK_KHZ;

    // ------------------------------------------------------------
    // config pin classes and register map
    // ------------------------------------------------------------
    localparam logic [1:0] OPT_OPEN = 2'h0;
    localparam logic [1:0] OPT_PULLUP = 2'h1;
    localparam logic [1:0] OPT_CAP = 2'h2;

    localparam int CAP_W = 10;
    localparam logic [CAP_W-1:0] CAP_RST = 10'h001;
    localparam logic [7:0] REG_CAP = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_KICKS = 8'h08;
    localparam int ST_LSB = 0;
    localparam int OPT_LSB = 8;
    localparam int EXP_BIT = 10;
    localparam int GST_BIT = 11;

    typedef enum logic [7:0] {
        S_LOWSUP = 8'h01,
        S_PROBE = 8'h02,
        S_OFF = 8'h04,
        S_SETTLE = 8'h08,
        S_RUN = 8'h10,
        S_EXPIRE = 8'h20,
        S_GATED = 8'h40,
        S_RELEASE = 8'h80
    } swg_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } swg_apb_req_s;

    typedef struct packed {
        swg_state_e st;
        logic [1:0] opt;
        logic expiry_n;
        logic gate_status;
        logic [15:0] kicks;
    } swg_stat_s;

endpackage : swg_pkg

// ==== design/swg_regs.sv ====
/*
 * APB slave holding the capacitor value and reporting watchdog status.
 * assumes APB3 signalling; every access answers with one wait state.
 */
`timescale 1ns/1ns
module swg_regs import swg_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input swg_apb_req_s req,
    input swg_stat_s stat,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [CAP_W-1:0] cap_nf
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [CAP_W-1:0] cap;
    } swg_regs_s;

    swg_regs_s q;
    swg_regs_s nxt_q;

    always_comb begin
        nxt_q = q;
        nxt_q.pready = 1'b0;
        nxt_q.pslverr = 1'b0;
        // registered answer keeps pready off a comb path
        if (req.psel && req.penable && !q.pready) begin
            nxt_q.pready = 1'b1;
            nxt_q.prdata = 32'h0000_0000;
            case (req.paddr)
                REG_CAP: begin
                    nxt_q.prdata[CAP_W-1:0] = q.cap;
                end
                REG_STATUS: begin
                    nxt_q.prdata[ST_LSB +: 8] = stat.st;
                    nxt_q.prdata[OPT_LSB +: 2] = stat.opt;
                    nxt_q.prdata[EXP_BIT] = stat.expiry_n;
                    nxt_q.prdata[GST_BIT] = stat.gate_status;
                end
                REG_KICKS: begin
                    nxt_q.prdata[15:0] = stat.kicks;
                end
                default: begin
                    nxt_q.pslverr = 1'b1;
                end
            endcase
        end
        if (req.psel && req.penable && q.pready && req.pwrite
            && req.paddr == REG_CAP) begin
            nxt_q.cap = req.pwdata[CAP_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
                   cap: CAP_RST};
        end else begin
            q <= nxt_q;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign cap_nf = q.cap;

endmodule : swg_regs

// ==== tb/swg_checker.sv ====
/*
 * port assertions and covers for the gated watchdog top.
 * assumes binding to swg_watchdog, one clock pclk, reset presetn.
 */
`timescale 1ns/1ns
module swg_checker import swg_pkg::*; #(
    parameter int P_STARTUP_CYC = STARTUP_CYC,
    parameter int P_RST_CYC = RST_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic supply_ok,
    input wire logic timer_arm_select,
    input wire logic gate_in,
    input wire logic kick_in,
    input wire logic expiry_out_n,
    input wire logic gate_status_out
);
    localparam int REL_MAX = P_RST_CYC + 2;
    logic [31:0] up_ff;
    logic run_ok;
    assign run_ok = gate_in && timer_arm_select && supply_ok;
    // ------------------------------------------------------------
    // cycles with supply good since reset or the last supply loss
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_ff <= 32'h0;
        else if (!supply_ok) up_ff <= 32'h0;
        else if (up_ff < 32'hFFFF) up_ff <= up_ff + 32'h1;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_gate_exp_rel: assert property (!gate_in |=> expiry_out_n)
        else $error("expiry not released while gated");
    chk_gate_stat_low: assert property (
        !gate_in [*7] |-> !gate_status_out)
        else $error("gate status high while gated");
    chk_rel_hold: assert property (
        $rose(gate_in) && !gate_status_out |=> !gate_status_out [*8])
        else $error("gate status released early");
    chk_sel_off: assert property (!timer_arm_select |=> expiry_out_n)
        else $error("expiry low while disabled");
    chk_low_supply: assert property (!supply_ok |=>
        expiry_out_n && !gate_status_out) else $error("low supply outputs");
    chk_startup_low: assert property (up_ff < P_STARTUP_CYC - 1 |->
        !gate_status_out) else $error("gate status high before startup");
    chk_exp_hold: assert property ($fell(expiry_out_n) && run_ok ##1
        run_ok [*7] |-> !expiry_out_n) else $error("expiry pulse too short");
    chk_exp_release: assert property ($fell(expiry_out_n) |->
        ##[1:REL_MAX] expiry_out_n) else $error("expiry pulse too long");
    chk_kick_safe: assert property (
        $fell(kick_in) && expiry_out_n |=> expiry_out_n [*4])
        else $error("expiry right after kick");
    chk_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    chk_rdy_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_rdy: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    cov_gate: cover property ($rose(gate_in));
    cov_expiry: cover property ($fell(expiry_out_n));
    cov_slverr: cover property (pslverr);
endmodule : swg_checker

bind swg_watchdog swg_checker #(
    .P_STARTUP_CYC(P_STARTUP_CYC), .P_RST_CYC(P_RST_CYC)
) u_swg_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
    .timer_arm_select(timer_arm_select), .gate_in(gate_in),
    .kick_in(kick_in), .expiry_out_n(expiry_out_n),
    .gate_status_out(gate_status_out)
);

// ==== tb/swg_kicker.sv ====
/*
 * supervised processor model issuing one-cycle low kicks.
 * assumes pclk; disabling it is how a scenario misses kicks.
 */
`timescale 1ns/1ns
module swg_kicker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic kick_en,
    input wire logic [15:0] kick_period,
    output logic kick_in
);
    logic [15:0] cnt_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 16'h0;
            kick_in <= 1'b1;
        end else if (!kick_en || cnt_ff < kick_period) begin
            cnt_ff <= kick_en ? cnt_ff + 16'h1 : 16'h0;
            kick_in <= 1'b1;
        end else begin
            // falling edge well inside the timeout
            cnt_ff <= 16'h0;
            kick_in <= 1'b0;
        end
    end
endmodule : swg_kicker

// ==== tb/tb_standard_watchdog_with_gate.sv ====
/*
 * self-checking bench for the gated watchdog with shortened counts.
 * assumes swg_watchdog, swg_kicker and the bound checker.
 */
`timescale 1ns/1ns
module tb_standard_watchdog_with_gate import swg_pkg::*;;
    localparam int T_RST = 20;
    localparam int T_LONG = 200;
    localparam int T_SHORT = 100;
    localparam int T_SLOPE = 10;
    localparam int T_BASE = 20;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, supply_ok = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] timeout_config_pin = OPT_PULLUP;
    logic timer_arm_select = 1'b1, gate_in = 1'b1, kick_in, err;
    logic expiry_out_n, gate_status_out, kick_en = 1'b0;
    logic [15:0] kick_period = 16'd50;
    int failures = 0, samples_checked = 0;
    always #25 pclk = ~pclk;
    swg_watchdog #(.P_PROBE_CYC(40), .P_STARTUP_CYC(30), .P_RST_CYC(T_RST),
        .P_WD_LONG_CYC(T_LONG), .P_WD_SHORT_CYC(T_SHORT),
        .P_CAP_SLOPE_CYC(T_SLOPE), .P_CAP_BASE_CYC(T_BASE)) u_swg_watchdog (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok),
        .timeout_config_pin(timeout_config_pin),
        .timer_arm_select(timer_arm_select), .gate_in(gate_in),
        .kick_in(kick_in), .expiry_out_n(expiry_out_n),
        .gate_status_out(gate_status_out));
    swg_kicker u_swg_kicker (.pclk(pclk), .presetn(presetn),
        .kick_en(kick_en), .kick_period(kick_period), .kick_in(kick_in));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        // only the bench watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic do_reset(input logic [1:0] cfg);
        presetn <= 1'b0;
        timeout_config_pin <= cfg;
        cyc(8);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask : do_reset
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, REG_CAP, 32'h0);
        check(rd, 32'(CAP_RST), "cap reset");
        cyc(60);
        apb(1'b0, REG_STATUS, 32'h0);
        check(32'(rd[11:8]), 32'({2'b11, OPT_PULLUP}),
              "status option");
        apb(1'b1, REG_CAP, 32'hFFFFFFFF);
        apb(1'b0, REG_CAP, 32'h0);
        check(rd, 32'h000003FF, "cap width");
        apb(1'b1, 8'h0C, 32'h12345678);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0, "unmapped data");
    endtask : t_regs
    task automatic t_alive;
        logic low;
        int nk;
        low = 1'b0;
        nk = 0;
        kick_en <= 1'b1;
        repeat (400) begin
            @(posedge pclk);
            if (expiry_out_n !== 1'b1) low = 1'b1;
            if (kick_in === 1'b0) nk++;
        end
        check({31'h0, low}, 32'h0, "kicked expiry");
        apb(1'b0, REG_KICKS, 32'h0);
        check(rd, 32'(nk), "kick count");
    endtask : t_alive
    task automatic t_gate;
        gate_in <= 1'b0;
        cyc(10);
        check(32'({expiry_out_n, gate_status_out}), 32'h2,
              "gated pins");
        kick_en <= 1'b0;
        cyc(300);
        check({31'h0, expiry_out_n}, 32'h1, "gated hold");
        kick_en <= 1'b1;
        gate_in <= 1'b1;
        cyc(10);
        check({31'h0, gate_status_out}, 32'h0, "release wait");
        cyc(20);
        check(32'({expiry_out_n, gate_status_out}), 32'h3,
              "released");
    endtask : t_gate
    task automatic t_select;
        // long disable goes through select, not gate
        timer_arm_select <= 1'b0;
        kick_en <= 1'b0;
        cyc(300);
        check({31'h0, expiry_out_n}, 32'h1, "disabled");
        timer_arm_select <= 1'b1;
        cyc(2000);
        apb(1'b0, REG_STATUS, 32'h0);
        check(rd & 32'hFF, 32'(S_SETTLE), "settle state");
        cyc(1200);
    endtask : t_select
    task automatic t_supply;
        supply_ok <= 1'b0;
        cyc(5);
        check(32'({expiry_out_n, gate_status_out}), 32'h2,
              "low supply");
        supply_ok <= 1'b1;
    endtask : t_supply
    task automatic t_timeout(input logic [1:0] cfg, input logic [31:0] cap,
                             input int tmo);
        int n_lo, n_hi;
        n_lo = 0;
        n_hi = 0;
        kick_en <= 1'b0;
        do_reset(cfg);
        apb(1'b1, REG_CAP, cap);
        repeat (1000) begin
            @(posedge pclk);
            if (expiry_out_n === 1'b0) break;
        end
        while (expiry_out_n === 1'b0 && n_lo < 100) begin
            @(posedge pclk);
            n_lo++;
        end
        while (expiry_out_n === 1'b1 && n_hi < 1000) begin
            @(posedge pclk);
            n_hi++;
        end
        check(32'(n_lo), 32'(T_RST), "expiry low span");
        check({31'h0, n_hi >= tmo - 1 && n_hi <= tmo + 3}, 32'h1,
              "timeout span");
    endtask : t_timeout
    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        do_reset(OPT_PULLUP);
        t_regs();
        t_alive();
        t_gate();
        t_select();
        t_supply();
        t_timeout(OPT_OPEN, 32'h1, T_LONG);
        t_timeout(OPT_PULLUP, 32'h1, T_SHORT);
        t_timeout(OPT_CAP, 32'h5, 5 * T_SLOPE + T_BASE);
        t_timeout(2'h3, 32'h1, T_LONG);
        print_verdict();
    end
    initial begin
        #(50 * 30000);
        failures++;
        print_verdict();
    end
endmodule : tb_standard_watchdog_with_gate
